/* core/bei_pkg.sv */
package bei_pkg;

  // register offsets on the slave control port
  localparam logic [7:0] BEI_OFS_DEV_NUM = 8'h46;
  localparam logic [7:0] BEI_OFS_ID0 = 8'h50;
  localparam logic [7:0] BEI_OFS_ID1 = 8'h51;
  localparam logic [7:0] BEI_OFS_ID2 = 8'h52;

  // field layout
  localparam int BEI_VER_LSB = 4;
  localparam int BEI_DEVNUM_W = 4;
  localparam logic [1:0] BEI_INST_HI_FIXED = 2'h0;
  localparam logic [3:0] BEI_DEVNUM_RESET = 4'h0;
  localparam logic [3:0] BEI_DEVNUM_MAX = 4'hB;

  // bus spec version codes
  localparam logic [3:0] BEI_VER_PRE_1_0 = 4'h0;
  localparam logic [3:0] BEI_VER_1_0 = 4'h1;

  // read data is a byte shifted out msb first
  localparam logic [2:0] BEI_LAST_BIT = 3'h0;
  localparam logic [2:0] BEI_FIRST_BIT = 3'h7;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bei_cmd_t;

  typedef enum logic [1:0] {
    BEI_IDLE = 2'b00,
    BEI_WAIT_RISE = 2'b01,
    BEI_WAIT_FALL = 2'b10
  } bei_state_t;

endpackage

/* core/bei_sync.sv */
module bei_sync import bei_pkg::*; #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // asynchronous levels, bit 0 is the link clock
  input wire logic [W-1:0] i_async,
  // synchronised levels and link clock edges
  output logic [W-1:0] o_sync,
  output logic o_rise,
  output logic o_fall
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic clk_last_reg;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          meta_reg[g] <= 1'b0;
          sync_reg[g] <= 1'b0;
        end else begin
          meta_reg[g] <= i_async[g];
          sync_reg[g] <= meta_reg[g];
        end
      end
    end
  endgenerate

  // edge finder looks only at the second stage
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      clk_last_reg <= 1'b0;
    end else begin
      clk_last_reg <= sync_reg[0];
    end
  end

  assign o_sync = sync_reg;
  assign o_rise = sync_reg[0] & ~clk_last_reg;
  assign o_fall = ~sync_reg[0] & clk_last_reg;

endmodule

/* core/bei_id_regs.sv */
module bei_id_regs import bei_pkg::*; #(
  parameter logic [3:0] BUS_SPEC_VERSION = BEI_VER_1_0,
  // arbitrary neutral value, not a registered maker code
  parameter logic [15:0] MAKER_CODE = 16'h0A5C
) (
  // clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  // decoded slave control port commands, one-cycle strobe
  input wire bei_cmd_t I_CMD,
  output logic O_CMD_BUSY,
  // link pins
  input wire logic I_LINK_CLK,
  input wire logic I_DATA_IN,
  output logic O_DATA_OUT,
  output logic O_DATA_OE,
  // straps
  input wire logic [1:0] I_ADDR_SEL,
  // answers
  output logic O_RD_DONE,
  output logic [7:0] O_RD_DATA,
  output logic O_WR_DONE,
  output logic O_WR_OK,
  // state
  output logic O_ENUM_ON,
  output logic [3:0] O_DEV_NUM
);

  logic [3:0] pin_sync;
  logic link_rise;
  logic link_fall;
  logic data_sync;
  logic [1:0] addr_sel_sync;

  bei_state_t state_reg;
  logic enum_on_reg;
  logic [3:0] dev_num_reg;
  logic [1:0] instance_lo_reg;
  logic strap_done_reg;
  logic [1:0] settle_reg;
  logic [7:0] shift_reg;
  logic [7:0] rd_data_reg;
  logic [2:0] bit_cnt_reg;
  logic id_read_reg;
  logic clash_reg;
  logic data_out_reg;
  logic data_oe_reg;
  logic rd_done_reg;
  logic wr_done_reg;
  logic wr_ok_reg;

  logic cmd_take;
  logic rd_take;
  logic wr_take;
  logic is_id_addr;
  logic enum_for_rd;
  logic [7:0] id_byte;
  logic [7:0] rd_byte;
  logic clash_now;
  logic devnum_wr_ok;

  bei_sync #(
    .W(4)
  ) u_sync (
    .i_clk(I_SYS_CLK),
    .i_rst_n(I_RST_N),
    .i_async({I_ADDR_SEL, I_DATA_IN, I_LINK_CLK}),
    .o_sync(pin_sync),
    .o_rise(link_rise),
    .o_fall(link_fall)
  );

  assign data_sync = pin_sync[1];
  assign addr_sel_sync = pin_sync[3:2];

  // commands arriving during a read shift are dropped
  assign cmd_take = (state_reg == BEI_IDLE) && strap_done_reg;
  assign rd_take = cmd_take && I_CMD.rd;
  assign wr_take = cmd_take && I_CMD.wr && !I_CMD.rd;
  assign is_id_addr = (I_CMD.addr == BEI_OFS_ID0) ||
                      (I_CMD.addr == BEI_OFS_ID1) ||
                      (I_CMD.addr == BEI_OFS_ID2);
  // the read that switches enumeration on already sees true data
  assign enum_for_rd = enum_on_reg || (I_CMD.addr == BEI_OFS_ID0);

  always_comb begin
    case (I_CMD.addr)
      BEI_OFS_ID0: id_byte = {BUS_SPEC_VERSION, BEI_INST_HI_FIXED,
                              instance_lo_reg};
      BEI_OFS_ID1: id_byte = MAKER_CODE[15:8];
      BEI_OFS_ID2: id_byte = MAKER_CODE[7:0];
      default: id_byte = 8'h00;
    endcase
  end

  always_comb begin
    if (is_id_addr) begin
      rd_byte = enum_for_rd ? id_byte : 8'h00;
    end else if (I_CMD.addr == BEI_OFS_DEV_NUM) begin
      rd_byte = {4'h0, dev_num_reg};
    end else begin
      rd_byte = 8'h00;
    end
  end

  // pin seen back through two flops, well inside half a link period
  assign clash_now = (state_reg == BEI_WAIT_FALL) && link_fall &&
                     id_read_reg && (data_sync != data_out_reg);
  assign devnum_wr_ok = enum_on_reg &&
                        (I_CMD.wdata[3:0] <= BEI_DEVNUM_MAX);

  // sync stages leave reset at zero; straps need two edges to get through
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      settle_reg <= 2'h0;
    end else begin
      settle_reg <= {settle_reg[0], 1'b1};
    end
  end

  // straps caught once, after the synchroniser has filled
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      instance_lo_reg <= 2'h0;
      strap_done_reg <= 1'b0;
    end else if (!strap_done_reg && settle_reg[1]) begin
      instance_lo_reg <= addr_sel_sync;
      strap_done_reg <= 1'b1;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      enum_on_reg <= 1'b0;
    end else if (clash_now) begin
      enum_on_reg <= 1'b0;
    end else if (rd_take && I_CMD.addr == BEI_OFS_ID0) begin
      enum_on_reg <= 1'b1;
    end
  end

  // writes to identification offsets fall through with no effect
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      dev_num_reg <= BEI_DEVNUM_RESET;
      wr_done_reg <= 1'b0;
      wr_ok_reg <= 1'b0;
    end else begin
      wr_done_reg <= wr_take;
      wr_ok_reg <= 1'b0;
      if (wr_take && I_CMD.addr == BEI_OFS_DEV_NUM && devnum_wr_ok) begin
        dev_num_reg <= I_CMD.wdata[3:0];
        wr_ok_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_reg <= BEI_IDLE;
      shift_reg <= 8'h00;
      rd_data_reg <= 8'h00;
      bit_cnt_reg <= BEI_FIRST_BIT;
      id_read_reg <= 1'b0;
      clash_reg <= 1'b0;
      data_out_reg <= 1'b0;
      data_oe_reg <= 1'b0;
      rd_done_reg <= 1'b0;
    end else begin
      rd_done_reg <= 1'b0;
      case (state_reg)
        BEI_IDLE: begin
          if (rd_take) begin
            shift_reg <= rd_byte;
            bit_cnt_reg <= BEI_FIRST_BIT;
            id_read_reg <= is_id_addr;
            clash_reg <= 1'b0;
            state_reg <= BEI_WAIT_RISE;
          end
        end
        BEI_WAIT_RISE: begin
          if (link_rise) begin
            data_out_reg <= shift_reg[7] & ~clash_reg;
            data_oe_reg <= 1'b1;
            state_reg <= BEI_WAIT_FALL;
          end
        end
        BEI_WAIT_FALL: begin
          if (link_fall) begin
            if (clash_now) begin
              clash_reg <= 1'b1;
            end
            rd_data_reg <= {rd_data_reg[6:0], data_out_reg};
            shift_reg <= {shift_reg[6:0], 1'b0};
            if (bit_cnt_reg == BEI_LAST_BIT) begin
              data_oe_reg <= 1'b0;
              data_out_reg <= 1'b0;
              rd_done_reg <= 1'b1;
              state_reg <= BEI_IDLE;
            end else begin
              bit_cnt_reg <= bit_cnt_reg - 3'h1;
              state_reg <= BEI_WAIT_RISE;
            end
          end
        end
        default: begin
          state_reg <= BEI_IDLE;
        end
      endcase
    end
  end

  assign O_CMD_BUSY = (state_reg != BEI_IDLE) || !strap_done_reg;
  assign O_DATA_OUT = data_out_reg;
  assign O_DATA_OE = data_oe_reg;
  assign O_RD_DONE = rd_done_reg;
  assign O_RD_DATA = rd_data_reg;
  assign O_WR_DONE = wr_done_reg;
  assign O_WR_OK = wr_ok_reg;
  assign O_ENUM_ON = enum_on_reg;
  assign O_DEV_NUM = dev_num_reg;

  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_N);

  sequence s_rd_id0;
    rd_take && I_CMD.addr == BEI_OFS_ID0;
  endsequence

  sequence s_clash;
    clash_now;
  endsequence

  property p_id0_read_enables;
    s_rd_id0 |=> enum_on_reg;
  endproperty
  a_id0_read_enables: assert property (p_id0_read_enables)
    else $error("id0 read did not switch enumeration on");

  property p_maker_true_when_on;
    rd_take && enum_on_reg && I_CMD.addr == BEI_OFS_ID1
      |=> shift_reg == MAKER_CODE[15:8];
  endproperty
  a_maker_true_when_on: assert property (p_maker_true_when_on)
    else $error("maker high byte wrong with enumeration on");

  property p_zero_when_off;
    rd_take && !enum_on_reg && I_CMD.addr == BEI_OFS_ID2
      |=> shift_reg == 8'h00;
  endproperty
  a_zero_when_off: assert property (p_zero_when_off)
    else $error("identification data leaked with enumeration off");

  property p_devnum_blocked;
    wr_take && !enum_on_reg && I_CMD.addr == BEI_OFS_DEV_NUM
      |=> $stable(dev_num_reg) && !wr_ok_reg;
  endproperty
  a_devnum_blocked: assert property (p_devnum_blocked)
    else $error("device number changed with enumeration off");

  property p_clash_drops;
    s_clash |=> !enum_on_reg && clash_reg;
  endproperty
  a_clash_drops: assert property (p_clash_drops)
    else $error("clash did not drop enumeration");

  // the clashed bit itself stays on the pin until the next rise
  property p_zero_after_clash;
    clash_reg && link_rise && state_reg == BEI_WAIT_RISE |=> !data_out_reg;
  endproperty
  a_zero_after_clash: assert property (p_zero_after_clash)
    else $error("nonzero bit driven after clash");

  property p_id0_layout;
    s_rd_id0 |=> shift_reg[7:4] == BUS_SPEC_VERSION &&
                 shift_reg[3:2] == BEI_INST_HI_FIXED &&
                 shift_reg[1:0] == instance_lo_reg;
  endproperty
  a_id0_layout: assert property (p_id0_layout)
    else $error("first id register layout wrong");

  property p_strap_latch;
    $rose(strap_done_reg) |-> instance_lo_reg == $past(addr_sel_sync);
  endproperty
  a_strap_latch: assert property (p_strap_latch)
    else $error("instance bits do not match straps");

  property p_reserved_devnum;
    wr_take && I_CMD.addr == BEI_OFS_DEV_NUM &&
      I_CMD.wdata[3:0] > BEI_DEVNUM_MAX |=> $stable(dev_num_reg);
  endproperty
  a_reserved_devnum: assert property (p_reserved_devnum)
    else $error("reserved device number accepted");

  property p_off_before_start;
    !strap_done_reg |-> !enum_on_reg && !data_oe_reg;
  endproperty
  a_off_before_start: assert property (p_off_before_start)
    else $error("enumeration on before first command");

  property p_maker_low_when_on;
    rd_take && enum_on_reg && I_CMD.addr == BEI_OFS_ID2
      |=> shift_reg == MAKER_CODE[7:0];
  endproperty
  a_maker_low_when_on: assert property (p_maker_low_when_on)
    else $error("maker low byte wrong with enumeration on");

  property p_id_write_ignored;
    wr_take && is_id_addr |=> $stable(dev_num_reg) && !wr_ok_reg &&
      $stable(enum_on_reg);
  endproperty
  a_id_write_ignored: assert property (p_id_write_ignored)
    else $error("write to identification register had an effect");

endmodule

/* testbench/bei_link_master.sv */
module bei_link_master (
  // frame request and fault injection
  input wire logic i_run,
  input wire logic [3:0] i_clash_at,
  // device side of the data pin
  input wire logic i_oe,
  input wire logic i_dout,
  // link pins
  output logic o_link_clk,
  output logic o_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] bit_cnt = 4'h0;
  logic tog = 1'b0;
  initial o_link_clk = 1'b0;
  // clock stands low outside an eight-bit read frame
  always begin
    wait (i_run);
    bit_cnt = 4'h0;
    #0.7;
    repeat (8) begin
      #16 o_link_clk = 1'b1;
      bit_cnt = bit_cnt + 4'h1;
      #16 o_link_clk = 1'b0;
    end
    wait (!i_run);
  end
  // released pin wanders so a stale bit cannot pass as data
  always #5 tog = ~tog;
  // zero selects no clash; otherwise that bit is overdriven
  assign o_data = !i_oe ? tog :
    (bit_cnt == i_clash_at) ? ~i_dout : i_dout;
endmodule

/* testbench/tb.sv */
module tb import bei_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  // arbitrary neutral value, not a registered maker code
  localparam logic [15:0] MAKER = 16'h5AE7;
  localparam logic [1:0] STRAPS = 2'h2;
  localparam logic [7:0] ID0 = {BEI_VER_1_0, 2'h0, STRAPS};
  localparam logic [1:0] STRAPS_ALT = 2'h1;
  localparam logic [7:0] ID0_ALT = {BEI_VER_1_0, 2'h0, STRAPS_ALT};
  logic [1:0] straps = STRAPS;
  logic I_SYS_CLK = 1'b0;
  logic I_RST_N = 1'b0;
  bei_cmd_t I_CMD = '0;
  logic link_clk, data_in, data_out, data_oe, busy;
  logic rd_done, wr_done, wr_ok, enum_on;
  logic [7:0] rd_data;
  logic [3:0] dev_num;
  logic run = 1'b0;
  logic [3:0] clash_at = 4'h0;
  logic [7:0] wire_byte = 8'h00;
  int errors = 0;
  int checks = 0;

  always #2 I_SYS_CLK = ~I_SYS_CLK;

  bei_id_regs #(.BUS_SPEC_VERSION(BEI_VER_1_0), .MAKER_CODE(MAKER)) dut (
    .I_SYS_CLK(I_SYS_CLK), .I_RST_N(I_RST_N), .I_CMD(I_CMD),
    .O_CMD_BUSY(busy), .I_LINK_CLK(link_clk), .I_DATA_IN(data_in),
    .O_DATA_OUT(data_out), .O_DATA_OE(data_oe), .I_ADDR_SEL(straps),
    .O_RD_DONE(rd_done), .O_RD_DATA(rd_data), .O_WR_DONE(wr_done),
    .O_WR_OK(wr_ok), .O_ENUM_ON(enum_on), .O_DEV_NUM(dev_num));

  bei_link_master master (.i_run(run), .i_clash_at(clash_at),
    .i_oe(data_oe), .i_dout(data_out), .o_link_clk(link_clk),
    .o_data(data_in));

  // wire level as seen by the master at each sampling edge
  always @(negedge link_clk) begin
    if (data_oe) begin
      wire_byte <= {wire_byte[6:0], data_in};
    end
  end

  task give_verdict;
    if (errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task do_reset;
    I_RST_N = 1'b0;
    repeat (3) @(posedge I_SYS_CLK);
    #1 I_RST_N = 1'b1;
    @(posedge I_SYS_CLK);
    #1;
  endtask

  task send(input logic rd, input logic [7:0] addr, input logic [7:0] wd);
    int n;
    n = 0;
    // let an edge pass so a strobe is never lowered and raised at once
    @(posedge I_SYS_CLK);
    #1;
    while (busy !== 1'b0) begin
      n = n + 1;
      if (n > 50) begin
        errors++;
        give_verdict();
      end
      @(posedge I_SYS_CLK);
      #1;
    end
    I_CMD = '{rd: rd, wr: ~rd, addr: addr, wdata: wd};
    run = rd;
    @(posedge I_SYS_CLK);
    #1 I_CMD = '0;
  endtask

  task wait_done(input logic rd);
    int n;
    n = 0;
    while ((rd ? rd_done : wr_done) !== 1'b1) begin
      n = n + 1;
      if (n > 300) begin
        errors++;
        give_verdict();
      end
      @(posedge I_SYS_CLK);
      #1;
    end
    run = 1'b0;
  endtask

  task do_read(input logic [7:0] addr, input logic [3:0] clash,
               input logic [7:0] exp);
    clash_at = clash;
    send(1'b1, addr, 8'h00);
    wait_done(1'b1);
    clash_at = 4'h0;
    check(rd_data, exp);
  endtask

  task do_write(input logic [7:0] addr, input logic [7:0] wd,
                input logic ok);
    send(1'b0, addr, wd);
    wait_done(1'b0);
    check({7'h0, wr_ok}, {7'h0, ok});
  endtask

  task scen_enum_off;
    check({7'h0, enum_on}, 8'h00);
    do_read(BEI_OFS_ID1, 4'h0, 8'h00);
    do_read(BEI_OFS_ID2, 4'h0, 8'h00);
    do_write(BEI_OFS_DEV_NUM, 8'h05, 1'b0);
    check({4'h0, dev_num}, 8'h00);
  endtask

  task scen_enumerate;
    do_read(BEI_OFS_ID0, 4'h0, ID0);
    check(wire_byte, ID0);
    check({7'h0, enum_on}, 8'h01);
    do_read(BEI_OFS_ID1, 4'h0, MAKER[15:8]);
    do_read(BEI_OFS_ID2, 4'h0, MAKER[7:0]);
    check(wire_byte, MAKER[7:0]);
  endtask

  task scen_dev_num;
    do_write(BEI_OFS_DEV_NUM, 8'h0B, 1'b1);
    check({4'h0, dev_num}, 8'h0B);
    do_write(BEI_OFS_DEV_NUM, 8'h0C, 1'b0);
    check({4'h0, dev_num}, 8'h0B);
    do_write(BEI_OFS_ID0, 8'hFF, 1'b0);
    do_write(BEI_OFS_ID1, 8'h00, 1'b0);
    do_read(BEI_OFS_ID0, 4'h0, ID0);
    do_read(BEI_OFS_ID1, 4'h0, MAKER[15:8]);
  endtask

  task scen_clash;
    // third bit overdriven: first three kept, the rest forced low
    do_read(BEI_OFS_ID2, 4'h3, MAKER[7:0] & 8'hE0);
    check({7'h0, enum_on}, 8'h00);
    do_write(BEI_OFS_DEV_NUM, 8'h03, 1'b0);
    check({4'h0, dev_num}, 8'h0B);
    do_read(BEI_OFS_ID1, 4'h0, 8'h00);
  endtask

  task scen_reset_again;
    do_read(BEI_OFS_ID0, 4'h0, ID0);
    check({7'h0, enum_on}, 8'h01);
    straps = STRAPS_ALT;
    do_reset();
    check({7'h0, enum_on}, 8'h00);
    check({4'h0, dev_num}, 8'h00);
    check({6'h0, busy, data_oe}, 8'h02);
    do_read(BEI_OFS_ID0, 4'h0, ID0_ALT);
    // straps move without a reset: instance must not follow
    straps = STRAPS;
    do_read(BEI_OFS_ID0, 4'h0, ID0_ALT);
  endtask

  initial begin
    do_reset();
    scen_enum_off();
    scen_enumerate();
    scen_dev_num();
    scen_clash();
    scen_reset_again();
    give_verdict();
  end
endmodule
